// *** dv/tcc_far_side.sv ***
module tcc_far_side
   import tcc_pkg::*;
(
   input wire logic hclk,
   output logic [3:0] count_pins,
   output logic [3:0] sibling_flags,
   output logic [3:0] sibling_compare
);
   timeunit 1ns;
   timeprecision 100ps;

   // Quiet levels at time zero
   initial begin
      count_pins = 4'h0;
      sibling_flags = 4'h0;
      sibling_compare = 4'h0;
   end

   // External count pins, changed just after an edge
   task automatic set_pins(input logic [3:0] v);
      count_pins <= v;
   endtask : set_pins

   // Output flags of the other channels, the only legal mode 7 source
   task automatic set_sib(input logic [3:0] v);
      sibling_flags <= v;
   endtask : set_sib

   // One-cycle compare pulse from another channel
   task automatic pulse_cmp(input logic [1:0] i);
      sibling_compare[i] <= 1'b1;
      @(posedge hclk);
      sibling_compare <= 4'h0;
   endtask : pulse_cmp
endmodule : tcc_far_side

// *** dv/timer_channel_count_control_tb.sv ***
module timer_channel_count_control_tb
   import tcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int LIMIT = 8000;
   localparam logic [1:0] QF [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
   localparam logic [1:0] QR [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
   typedef struct packed {
      logic [15:0] ctrl;
      logic inv;
      logic [15:0] load;
      logic [15:0] up;
      logic [15:0] down;
      logic [15:0] start;
      logic [3:0] aux;
      logic [3:0] n;
      logic [15:0] exp;
      logic flag;
   } tcc_row_t;
   // Control word, invert, load, matches, start, pin levels, pulses, count, flag
   localparam tcc_row_t ROWS [17] = '{
      '{16'h0000, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h0, 4'h3, 16'h0, 1'b0},
      '{16'h2200, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h0, 4'h3, 16'h3, 1'b1},
      '{16'h4401, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h0, 4'h3, 16'h6, 1'b0},
      '{16'h2010, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h5, 4'h0, 4'h3, 16'h2, 1'b1},
      '{16'h6180, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h8, 4'h3, 16'h3, 1'b1},
      '{16'h6100, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h8, 4'h3, 16'h0, 1'b1},
      '{16'ha180, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'ha, 4'h8, 4'h3, 16'h7, 1'b1},
      '{16'ha080, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'ha, 4'h8, 4'h3, 16'hd, 1'b1},
      '{16'h2023, 1'b0, 16'h2, 16'h4, 16'h0f00, 16'h2, 4'h0, 4'h3, 16'h2, 1'b1},
      '{16'h2002, 1'b0, 16'h0, 16'h4, 16'h0f00, 16'h2, 4'h0, 4'h3, 16'h5, 1'b1},
      '{16'h2033, 1'b0, 16'h9, 16'h0f00, 16'h7, 16'h9, 4'h0, 4'h3, 16'h9, 1'b1},
      '{16'h2024, 1'b0, 16'h0, 16'h2, 16'h1, 16'h0, 4'h0, 4'h4, 16'h1, 1'b1},
      '{16'h2024, 1'b0, 16'h0, 16'h2, 16'h1, 16'h0, 4'h0, 4'h5, 16'h0, 1'b0},
      '{16'h2006, 1'b0, 16'h0, 16'hfffe, 16'h0f00, 16'hfffe, 4'h0, 4'h3, 16'h1, 1'b0},
      '{16'h2a00, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h0, 4'h3, 16'h3, 1'b1},
      '{16'hee10, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h5, 4'h0, 4'h3, 16'h2, 1'b1},
      '{16'h2800, 1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h0, 4'h3, 16'h0, 1'b1}
   };

   logic hclk;
   logic hresetn;
   tcc_ahb_req_t mreq;
   tcc_ahb_req_t dut_req;
   tcc_ahb_rsp_t rsp;
   logic [3:0] pins;
   logic [3:0] far_flags;
   logic [3:0] far_cmp;
   logic channel_output_flag;
   logic compare_event;
   logic rollover_event;
   int failures;
   int check_count;
   int cycles;
   int cmp_seen;
   int roll_seen;

   // Single slave, so the bus hready is its own hreadyout
   assign dut_req = {mreq[$bits(tcc_ahb_req_t)-1:1], rsp.hreadyout};

   tcc_far_side u_far(.hclk(hclk), .count_pins(pins), .sibling_flags(far_flags), .sibling_compare(far_cmp));

   // Bit 0 of the sibling buses is this channel itself
   tcc_channel #(.CHANNEL_INDEX(2'h0)) u_dut(.hclk(hclk), .hresetn(hresetn), .ahb_req(dut_req), .ahb_rsp(rsp),
      .count_pins(pins), .sibling_outputs({far_flags[3:1], channel_output_flag}),
      .sibling_compare({far_cmp[3:1], compare_event}), .channel_output_flag(channel_output_flag),
      .compare_event(compare_event), .rollover_event(rollover_event));

   // Clock at 40 MHz
   initial hclk = 1'b0;
   always #12.5 hclk = ~hclk;

   task automatic end_sim;
      if (failures == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim

   // Hang guard
   always @(posedge hclk) begin
      cycles++;
      // Tally of the one-cycle event pulses
      if (compare_event === 1'b1) cmp_seen++;
      if (rollover_event === 1'b1) roll_seen++;
      if (cycles == LIMIT) begin
         failures++;
         end_sim();
      end
   end

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
      end
   endtask : chk1

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick

   // One single AHB-Lite word transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      mreq.hsel <= 1'b1;
      mreq.haddr <= {24'h000000, a};
      mreq.htrans <= HTRANS_NONSEQ;
      mreq.hwrite <= wr;
      mreq.hsize <= 3'h2;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      mreq.hsel <= 1'b0;
      mreq.htrans <= 2'h0;
      mreq.hwdata <= wd;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      rd = rsp.hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] x;
      bus(1'b1, a, {16'h0000, d}, x);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] v;
      bus(1'b0, a, 32'h00000000, v);
      chk32(v, {16'h0000, e});
   endtask : rd_chk

   // Stop the channel, then set up its words and pin levels
   task automatic prep(input logic inv, input logic [15:0] ld, input logic [15:0] up, input logic [15:0] dn,
      input logic [15:0] st, input logic [3:0] lvl);
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_CONFIG, {15'h0000, inv});
      wr(OFS_LOAD, ld);
      wr(OFS_UP_MATCH, up);
      wr(OFS_DOWN_MATCH, dn);
      wr(OFS_COUNT, st);
      u_far.set_pins(lvl);
      u_far.set_sib(4'h0);
      tick(8);
   endtask : prep

   // One high pulse on a count pin or a sibling flag
   task automatic pulse(input logic [2:0] i, input logic [3:0] base);
      logic [3:0] b;
      b = 4'h1 << i[1:0];
      if (i[2]) u_far.set_sib(b);
      else u_far.set_pins(base | b);
      tick(4);
      if (i[2]) u_far.set_sib(4'h0);
      else u_far.set_pins(base);
      tick(4);
   endtask : pulse

   task automatic reinit(input logic [15:0] c, input logic [1:0] i, input logic [15:0] e);
      wr(OFS_CTRL, c);
      wr(OFS_COUNT, 16'h0100);
      u_far.pulse_cmp(i);
      tick(3);
      rd_chk(OFS_COUNT, e);
   endtask : reinit

   initial begin
      logic [31:0] v0;
      logic [31:0] v1;
      logic [15:0] d;
      tcc_row_t r;
      logic f;
      int e;
      int c0;
      int r0;
      mreq = '0;
      hresetn = 1'b0;
      tick(12);
      hresetn <= 1'b1;
      tick(1);
      // Reset values, upper bits, read-only status, unmapped word
      for (int a = 0; a < 8; a++) rd_chk(8'(a * 4), 16'h0000);
      bus(1'b1, OFS_LOAD, 32'hffffffff, v0);
      rd_chk(OFS_LOAD, 16'hffff);
      bus(1'b1, OFS_STATUS, 32'hffffffff, v0);
      rd_chk(OFS_STATUS, 16'h0000);
      bus(1'b1, 8'h1c, 32'hffffffff, v0);
      rd_chk(8'h1c, 16'h0000);
      // Table of counting cases
      foreach (ROWS[i]) begin
         r = ROWS[i];
         prep(r.inv, r.load, r.up, r.down, r.start, r.aux);
         wr(OFS_CTRL, r.ctrl);
         repeat (r.n) pulse(r.ctrl[11:9], r.aux);
         tick(8);
         rd_chk(OFS_COUNT, r.exp);
         chk1(channel_output_flag, r.flag);
      end
      // One compare pulse at the match and one rollover pulse at the wrap
      prep(1'b0, 16'h0, 16'hffff, 16'h0f00, 16'hfffe, 4'h0);
      wr(OFS_CTRL, 16'h2000);
      c0 = cmp_seen;
      r0 = roll_seen;
      repeat (2) pulse(3'h0, 4'h0);
      chk32(cmp_seen - c0, 32'h1);
      chk32(roll_seen - r0, 32'h1);
      // Inverted input counts falling pin edges
      prep(1'b1, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h0);
      wr(OFS_CTRL, 16'h2000);
      u_far.set_pins(4'h1);
      tick(8);
      rd_chk(OFS_COUNT, 16'h0000);
      u_far.set_pins(4'h0);
      tick(8);
      rd_chk(OFS_COUNT, 16'h0001);
      // Quadrature: two full cycles forward, one back
      prep(1'b0, 16'h0, 16'h0f00, 16'h0f00, 16'h0, 4'h0);
      wr(OFS_CTRL, 16'h8080);
      for (int i = 0; i < 12; i++) begin
         u_far.set_pins({2'b00, i < 8 ? QF[i % 4] : QR[i % 4]});
         tick(5);
      end
      rd_chk(OFS_COUNT, 16'h0004);
      // Triggered counting with set-on-compare, clear-on-aux-edge flag
      prep(1'b0, 16'h0, 16'h2, 16'h0f00, 16'h0, 4'h0);
      wr(OFS_CTRL, 16'hc1a5);
      repeat (2) pulse(3'h0, 4'h0);
      rd_chk(OFS_COUNT, 16'h0000);
      u_far.set_pins(4'h8);
      tick(6);
      repeat (3) pulse(3'h0, 4'h8);
      chk1(channel_output_flag, 1'b1);
      repeat (2) pulse(3'h0, 4'h8);
      rd_chk(OFS_COUNT, 16'h0000);
      u_far.set_pins(4'h0);
      tick(6);
      u_far.set_pins(4'h8);
      tick(8);
      chk1(channel_output_flag, 1'b0);
      // Gated clock flag while active, low when idle
      wr(OFS_CTRL, 16'h2007);
      tick(4);
      f = channel_output_flag;
      tick(1);
      chk1(channel_output_flag ^ f, 1'b1);
      wr(OFS_CTRL, 16'h0007);
      tick(4);
      chk1(channel_output_flag, 1'b0);
      // Reload forced by another channel's compare
      wr(OFS_LOAD, 16'h0033);
      reinit(16'h0008, 2'h1, 16'h0033);
      reinit(16'h0008, 2'h3, 16'h0033);
      reinit(16'h0000, 2'h2, 16'h0100);
      // Prescaled clock rates, mode 1 only since both-edge use of div 1 is barred
      for (int s = 0; s < 8; s++) begin
         wr(OFS_CTRL, 16'h0000);
         wr(OFS_CONFIG, 16'h0001);
         wr(OFS_CTRL, {3'h1, 1'b1, s[2:0], 9'h000});
         bus(1'b0, OFS_COUNT, 32'h00000000, v0);
         tick(256);
         bus(1'b0, OFS_COUNT, 32'h00000000, v1);
         e = 258 >> s;
         d = v1[15:0] - v0[15:0];
         chk1(d >= e - 2 && d <= e + 2, 1'b1);
      end
      end_sim();
   end
endmodule : timer_channel_count_control_tb

// *** hdl/tcc_channel.sv ***
// Behaviour
// - Length bit reloads from load value on compare; clear counts on to rollover.
// - Compare uses upward match counting up, downward match counting down.
// - Flag behaviour 4 alternates the compare target between both match values.
// - Direction bit set counts down, clear counts up; up after reset.
// - Sibling reinit bit lets another channel's compare reload this counter.
// - Mode 0 idles, mode 1 counts rising edges, mode 2 counts both edges.
// - Mode 3 counts rising edges only while the auxiliary input is high.
// - Mode 4 decodes main and auxiliary inputs as quadrature, up or down.
// - Mode 5 counts rising edges, down when auxiliary input is one.
// - Mode 6 starts counting on auxiliary edge, runs until a compare.
// - Mode 7 is synchronous up/down counting off a sibling channel output.
// - Single-edge modes count rising edges, or falling edges when inverted.
// - Undivided clock source counts every clock, inversion ignored.
// - Main select picks pins, channel outputs or clock prescaled 1 to 128.
// - Selecting the channel's own output as main source gives no counting.
// - Auxiliary select picks input pin 0 to 3.
// - Flag 0 shows activity; flag 7 drives a gated clock while active.
// - Flags 1, 2, 3 clear, set or toggle the output on each compare.
// - Flag 4 toggles the output on compares against alternating match values.
// - Flag 5 sets on compare, clears on aux edge; 6 clears on rollover.
//
// Chosen here: the register addresses and the AHB-Lite register port.
module tcc_channel
   import tcc_pkg::*;
#(
   parameter logic [1:0] CHANNEL_INDEX = 2'h0
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire tcc_ahb_req_t ahb_req,
   output tcc_ahb_rsp_t ahb_rsp,
   input wire logic [3:0] count_pins,
   input wire logic [3:0] sibling_outputs,
   input wire logic [3:0] sibling_compare,
   output logic channel_output_flag,
   output logic compare_event,
   output logic rollover_event
);

   tcc_state_t st;
   tcc_state_t next_st;
   logic [3:0] pins_sync;

   // Combinational view of the counting path, also watched by the checks
   logic main_lvl;
   logic main_rise;
   logic main_fall;
   logic div1;
   logic own_src;
   logic aux_lvl;
   logic aux_edge;
   logic cnt_event;
   logic cnt_down;
   logic hit;
   logic reinit;
   logic addr_take;
   logic cnt_wr;
   logic [15:0] target;
   logic [2:0] div_sel;

   // External count pins come in asynchronously
   tcc_pin_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pins_async(count_pins),
      .pins_sync(pins_sync)
   );

   // Read mux for the address phase
   function automatic logic [31:0] read_word(input tcc_state_t s, input logic [7:0] addr);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (addr)
         OFS_CTRL: w = {16'h0000, s.ctrl};
         OFS_CONFIG: w[CFG_INVERT_BIT] = s.invert;
         OFS_LOAD: w = {16'h0000, s.load};
         OFS_UP_MATCH: w = {16'h0000, s.up_match};
         OFS_DOWN_MATCH: w = {16'h0000, s.down_match};
         OFS_COUNT: w = {16'h0000, s.count};
         OFS_STATUS: begin
            w[STAT_FLAG_BIT] = s.flag;
            w[STAT_AUX_BIT] = s.aux_q;
            w[STAT_TRIG_BIT] = s.triggered;
            w[STAT_ALT_BIT] = s.alt_sel;
         end
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction : read_word

   // Main source selection and edge detection
   always_comb begin
      div_sel = st.ctrl.main_source_select[2:0];
      div1 = 1'b0;
      main_lvl = 1'b0;
      case (st.ctrl.main_source_select[3:2])
         SRC_PIN: main_lvl = pins_sync[st.ctrl.main_source_select[1:0]];
         SRC_SIBLING: main_lvl = sibling_outputs[st.ctrl.main_source_select[1:0]];
         default: begin
            if (div_sel == 3'h0) begin
               div1 = 1'b1;
            end else begin
               main_lvl = st.presc[3'(div_sel - 3'h1)];
            end
         end
      endcase
      main_lvl = main_lvl ^ st.invert;
      main_rise = main_lvl & ~st.main_q;
      main_fall = ~main_lvl & st.main_q;
      if (div1) begin
         main_rise = 1'b1;
         main_fall = 1'b0;
      end
      own_src = (st.ctrl.main_source_select == {SRC_SIBLING, CHANNEL_INDEX});
      aux_lvl = pins_sync[st.ctrl.aux_pin_select] ^ st.invert;
      aux_edge = aux_lvl & ~st.aux_q;
   end

   // Counting mode decode
   always_comb begin
      cnt_event = 1'b0;
      cnt_down = st.ctrl.dir;
      case (st.ctrl.count_mode)
         MODE_NONE: cnt_event = 1'b0;
         MODE_RISE: cnt_event = main_rise;
         MODE_BOTH: cnt_event = main_rise | main_fall;
         MODE_GATED: cnt_event = main_rise & aux_lvl;
         MODE_QUAD: begin
            cnt_event = (main_lvl ^ st.main_q) ^ (aux_lvl ^ st.aux_q);
            if (main_lvl ^ st.main_q) begin
               cnt_down = (main_lvl == aux_lvl);
            end else begin
               cnt_down = (main_lvl != aux_lvl);
            end
         end
         MODE_DIRSEC: begin
            cnt_event = main_rise;
            cnt_down = aux_lvl;
         end
         MODE_TRIG: cnt_event = main_rise & st.triggered;
         MODE_SYNC: cnt_event = main_rise & (st.ctrl.main_source_select[3:2] == SRC_SIBLING);
         default: cnt_event = 1'b0;
      endcase
      if (own_src) begin
         cnt_event = 1'b0;
      end
   end

   // Compare target, compare hit and sibling reload request
   always_comb begin
      if (st.ctrl.flag_mode == FLAG_ALT) begin
         target = st.alt_sel ? st.down_match : st.up_match;
      end else begin
         target = cnt_down ? st.down_match : st.up_match;
      end
      hit = cnt_event & (st.count == target);
      reinit = st.ctrl.sibling_reinit_enable & (|(sibling_compare & ~(4'h1 << CHANNEL_INDEX)));
      addr_take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
      cnt_wr = st.wr_pend & (st.wr_addr == OFS_COUNT);
   end

   // Next state of counter, flag and bus slave
   always_comb begin
      next_st = st;
      next_st.compare = hit;
      next_st.rollover = 1'b0;
      next_st.presc = st.presc + 7'h01;
      next_st.main_q = main_lvl;
      next_st.aux_q = aux_lvl;
      // Counter
      if (reinit) begin
         next_st.count = st.load;
      end else if (cnt_event) begin
         if (hit && st.ctrl.length) begin
            next_st.count = st.load;
         end else if (cnt_down) begin
            next_st.count = st.count - 16'h0001;
            next_st.rollover = (st.count == 16'h0000);
         end else begin
            next_st.count = st.count + 16'h0001;
            next_st.rollover = (st.count == 16'hffff);
         end
      end
      // Alternating compare target
      if (hit && st.ctrl.flag_mode == FLAG_ALT) begin
         next_st.alt_sel = ~st.alt_sel;
      end
      // Trigger latch; a new auxiliary edge wins over the compare that ends a run
      if (st.ctrl.count_mode != MODE_TRIG) begin
         next_st.triggered = 1'b0;
      end else if (aux_edge) begin
         next_st.triggered = 1'b1;
      end else if (hit) begin
         next_st.triggered = 1'b0;
      end
      // Output flag
      case (st.ctrl.flag_mode)
         FLAG_ACTIVE: next_st.flag = (st.ctrl.count_mode != MODE_NONE);
         FLAG_CLEAR: next_st.flag = hit ? 1'b0 : st.flag;
         FLAG_SET: next_st.flag = hit ? 1'b1 : st.flag;
         FLAG_TOGGLE: next_st.flag = st.flag ^ hit;
         FLAG_ALT: next_st.flag = st.flag ^ hit;
         FLAG_SET_AUX: begin
            if (hit) begin
               next_st.flag = 1'b1;
            end else if (aux_edge) begin
               next_st.flag = 1'b0;
            end
         end
         FLAG_SET_ROLL: begin
            if (hit) begin
               next_st.flag = 1'b1;
            end else if (next_st.rollover) begin
               next_st.flag = 1'b0;
            end
         end
         FLAG_GATED_CLK: next_st.flag = (st.ctrl.count_mode != MODE_NONE) & ~st.flag;
         default: next_st.flag = st.flag;
      endcase
      // Bus data phase: a write lands after the counting update and wins
      if (st.wr_pend) begin
         case (st.wr_addr)
            OFS_CTRL: next_st.ctrl = ahb_req.hwdata[15:0];
            OFS_CONFIG: next_st.invert = ahb_req.hwdata[CFG_INVERT_BIT];
            OFS_LOAD: next_st.load = ahb_req.hwdata[15:0];
            OFS_UP_MATCH: next_st.up_match = ahb_req.hwdata[15:0];
            OFS_DOWN_MATCH: next_st.down_match = ahb_req.hwdata[15:0];
            OFS_COUNT: next_st.count = ahb_req.hwdata[15:0];
            default: next_st.wr_pend = 1'b0;
         endcase
      end
      // Bus address phase
      next_st.wr_pend = addr_take & ahb_req.hwrite;
      if (addr_take) begin
         next_st.wr_addr = ahb_req.haddr[7:0];
         if (!ahb_req.hwrite) begin
            next_st.rdata = read_word(st, ahb_req.haddr[7:0]);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign ahb_rsp.hrdata = st.rdata;
   assign ahb_rsp.hreadyout = 1'b1;
   assign ahb_rsp.hresp = 1'b0;
   assign channel_output_flag = st.flag;
   assign compare_event = st.compare;
   assign rollover_event = st.rollover;

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_reload_on_match: assert property (
      (hit && st.ctrl.length && !reinit && !cnt_wr) |=> (st.count == $past(st.load)))
      else $error("counter did not reload on compare");

   chk_pass_on_match: assert property (
      (hit && !st.ctrl.length && !cnt_down && !reinit && !cnt_wr) |=> (st.count == $past(st.count) + 16'h0001))
      else $error("counter did not pass the compare value");

   chk_down_target: assert property (
      (cnt_event && cnt_down && st.ctrl.flag_mode != FLAG_ALT && st.count == st.down_match) |=> st.compare)
      else $error("down count missed the downward match");

   chk_alt_switch: assert property (
      (hit && st.ctrl.flag_mode == FLAG_ALT) |=> (st.alt_sel != $past(st.alt_sel)) && (st.flag != $past(st.flag)))
      else $error("alternating target or flag did not switch");

   chk_count_down: assert property (
      (st.ctrl.count_mode == MODE_RISE && cnt_event && st.ctrl.dir && !hit && !reinit && !cnt_wr)
      |=> (st.count == $past(st.count) - 16'h0001))
      else $error("counter did not step down");

   chk_sibling_reload: assert property (
      (reinit && !cnt_wr) |=> (st.count == $past(st.load)))
      else $error("sibling compare did not reload");

   chk_idle_stable: assert property (
      (st.ctrl.count_mode == MODE_NONE && !reinit && !cnt_wr) |=> $stable(st.count))
      else $error("counter moved with counting off");

   chk_own_source: assert property (
      (own_src && !reinit && !cnt_wr) |=> $stable(st.count))
      else $error("counter moved on its own output");

   chk_flag_active: assert property (
      (st.ctrl.flag_mode == FLAG_ACTIVE) |=> (st.flag == ($past(st.ctrl.count_mode) != MODE_NONE)))
      else $error("flag does not follow activity");

   chk_flag_toggle: assert property (
      (hit && st.ctrl.flag_mode == FLAG_TOGGLE) |=> (st.flag != $past(st.flag)))
      else $error("flag did not toggle on compare");

   chk_roll_clear: assert property (
      (st.ctrl.flag_mode == FLAG_SET_ROLL && next_st.rollover && !hit) |=> !st.flag && st.rollover)
      else $error("flag not cleared on rollover");

   // Checks per counting mode and flag behaviour
   chk_gated_clock: assert property (
      (st.ctrl.flag_mode == FLAG_GATED_CLK && st.ctrl.count_mode != MODE_NONE) |=> (st.flag != $past(st.flag)))
      else $error("gated clock flag did not toggle");

   chk_trigger_arm: assert property (
      (st.ctrl.count_mode == MODE_TRIG && aux_edge) |=> st.triggered)
      else $error("auxiliary edge did not arm counting");

   chk_aux_clear: assert property (
      (st.ctrl.flag_mode == FLAG_SET_AUX && aux_edge && !hit) |=> !st.flag)
      else $error("flag not cleared on auxiliary edge");

   chk_gated_idle: assert property (
      (st.ctrl.count_mode == MODE_GATED && main_rise && !aux_lvl && !reinit && !cnt_wr)
      |=> $stable(st.count))
      else $error("counter moved with the gate low");

   chk_dir_by_aux: assert property (
      (st.ctrl.count_mode == MODE_DIRSEC && cnt_event && aux_lvl && !hit && !reinit && !cnt_wr)
      |=> (st.count == $past(st.count) - 16'h0001))
      else $error("auxiliary high did not step down");

   chk_set_on_match: assert property (
      (hit && st.ctrl.flag_mode == FLAG_SET) |=> st.flag)
      else $error("flag not set on compare");

   chk_div1_step: assert property (
      (st.ctrl.count_mode == MODE_RISE && div1 && !st.ctrl.dir && !hit && !reinit && !cnt_wr)
      |=> (st.count == $past(st.count) + 16'h0001))
      else $error("undivided clock did not count every cycle");

   cov_alt_compare: cover property (st.compare && st.ctrl.flag_mode == FLAG_ALT);
   cov_gated_count: cover property (st.ctrl.count_mode == MODE_GATED && cnt_event);
   cov_rollover: cover property (st.rollover);
   cov_quad_down: cover property (st.ctrl.count_mode == MODE_QUAD && cnt_event && cnt_down);
   cov_sibling: cover property (reinit);

endmodule : tcc_channel

// *** hdl/tcc_pin_sync.sv ***
module tcc_pin_sync
   import tcc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] pins_async,
   output logic [3:0] pins_sync
);

   tcc_sync_state_t st;
   tcc_sync_state_t next_st;

   // Two flip-flops per pin; only the second stage leaves this module
   always_comb begin
      next_st = st;
      next_st.stage1 = pins_async;
      next_st.stage2 = st.stage1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pins_sync = st.stage2;

endmodule : tcc_pin_sync

// *** include/tcc_pkg.sv ***
package tcc_pkg;

   // Register byte offsets inside the channel window
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_LOAD = 8'h08;
   localparam logic [7:0] OFS_UP_MATCH = 8'h0c;
   localparam logic [7:0] OFS_DOWN_MATCH = 8'h10;
   localparam logic [7:0] OFS_COUNT = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // Field positions of channel_control
   localparam int CTRL_MODE_LSB = 13;
   localparam int CTRL_SRC_LSB = 9;
   localparam int CTRL_AUX_LSB = 7;
   localparam int CTRL_ONCE_BIT = 6;
   localparam int CTRL_LENGTH_BIT = 5;
   localparam int CTRL_DIR_BIT = 4;
   localparam int CTRL_REINIT_BIT = 3;
   localparam int CTRL_FLAG_LSB = 0;

   // Field positions of the config and status words
   localparam int CFG_INVERT_BIT = 0;
   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_AUX_BIT = 1;
   localparam int STAT_TRIG_BIT = 2;
   localparam int STAT_ALT_BIT = 3;

   // Reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] WORD16_RST = 16'h0000;

   // Clock and prescaler
   localparam int CLK_PERIOD_NS = 25;
   localparam int PRESC_W = 7;

   // Counting modes
   localparam logic [2:0] MODE_NONE = 3'h0;
   localparam logic [2:0] MODE_RISE = 3'h1;
   localparam logic [2:0] MODE_BOTH = 3'h2;
   localparam logic [2:0] MODE_GATED = 3'h3;
   localparam logic [2:0] MODE_QUAD = 3'h4;
   localparam logic [2:0] MODE_DIRSEC = 3'h5;
   localparam logic [2:0] MODE_TRIG = 3'h6;
   localparam logic [2:0] MODE_SYNC = 3'h7;

   // Output flag behaviours
   localparam logic [2:0] FLAG_ACTIVE = 3'h0;
   localparam logic [2:0] FLAG_CLEAR = 3'h1;
   localparam logic [2:0] FLAG_SET = 3'h2;
   localparam logic [2:0] FLAG_TOGGLE = 3'h3;
   localparam logic [2:0] FLAG_ALT = 3'h4;
   localparam logic [2:0] FLAG_SET_AUX = 3'h5;
   localparam logic [2:0] FLAG_SET_ROLL = 3'h6;
   localparam logic [2:0] FLAG_GATED_CLK = 3'h7;

   // Main source groups (upper two select bits)
   localparam logic [1:0] SRC_PIN = 2'h0;
   localparam logic [1:0] SRC_SIBLING = 2'h1;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic [2:0] count_mode;
      logic [3:0] main_source_select;
      logic [1:0] aux_pin_select;
      logic once;
      logic length;
      logic dir;
      logic sibling_reinit_enable;
      logic [2:0] flag_mode;
   } tcc_ctrl_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } tcc_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } tcc_ahb_rsp_t;

   typedef struct packed {
      tcc_ctrl_t ctrl;
      logic invert;
      logic [15:0] load;
      logic [15:0] up_match;
      logic [15:0] down_match;
      logic [15:0] count;
      logic flag;
      logic [PRESC_W-1:0] presc;
      logic main_q;
      logic aux_q;
      logic triggered;
      logic alt_sel;
      logic compare;
      logic rollover;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } tcc_state_t;

   typedef struct packed {
      logic [3:0] stage1;
      logic [3:0] stage2;
   } tcc_sync_state_t;

endpackage : tcc_pkg
